// ---- rtl/dispatch_pkg.sv ----
// Constants, codes, offsets and types for the digital input function dispatch block.
package dispatch_pkg;
    // Block dimensions.
    localparam int IN_COUNT = 8;
    localparam int OUT_COUNT = 6;
    localparam int CODE_W = 7;
    localparam int FN_COUNT = 50;
    localparam int ADDR_W = 12;
    // Input function codes that the dispatch logic treats specially.
    localparam int FN_NONE = 0;
    localparam int FN_ENABLE = 1;
    localparam int FN_DRIVE_RESET = 2;
    localparam int FN_TQ_FIRST = 3;
    localparam int FN_TQ_LAST = 13;
    localparam int FN_FW_RESET = 14;
    localparam int FN_ENC_CLEAR = 15;
    localparam int FN_SPEED_SEL0 = 17;
    localparam int FN_SPEED_SEL3 = 20;
    localparam int FN_POS_INHIBIT = 21;
    localparam int FN_POS_REVERSE = 22;
    localparam int FN_PULSE_INHIBIT = 23;
    localparam int FN_ERR_CLEAR = 25;
    localparam int FN_HOME_START = 26;
    localparam int FN_SEG_TRIGGER = 27;
    localparam int FN_SEG_SEL0 = 28;
    localparam int FN_SEG_SEL3 = 31;
    localparam int FN_SEG_DIR = 32;
    localparam int FN_UNASSIGNED = 33;
    localparam int FN_ORIGIN = 34;
    localparam int FN_MODE_SEL0 = 36;
    localparam int FN_MODE_SEL1 = 37;
    localparam int FN_FIXLEN_DETECT = 38;
    localparam int FN_FIXLEN_CANCEL = 39;
    localparam int FN_FIXLEN_TRIGGER = 40;
    localparam int FN_LIMIT_POS = 43;
    localparam int FN_LIMIT_NEG = 44;
    localparam int FN_LOGIC_RESET = 46;
    // Register byte offsets; the code registers are one word per input.
    localparam logic [ADDR_W-1:0] ADDR_CODE_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_POLARITY = 12'h020;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 12'h024;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_LO = 12'h028;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_HI = 12'h02c;
    localparam logic [ADDR_W-1:0] ADDR_OUT_STATUS = 12'h030;
    // Field positions in the polarity register, one bit per output.
    localparam int OUTPUT_ONE_POLARITY_BIT = 0;
    localparam int OUTPUT_TWO_POLARITY_BIT = 1;
    localparam int OUTPUT_THREE_POLARITY_BIT = 2;
    localparam int OUTPUT_FOUR_POLARITY_BIT = 3;
    localparam int OUTPUT_FIVE_POLARITY_BIT = 4;
    localparam int OUTPUT_SIX_POLARITY_BIT = 5;
    // Field positions in the mode register.
    localparam int MODE_ERR_EDGE_BIT = 0;
    localparam int MODE_ORIGIN_EDGE_BIT = 1;
    // Reset values.
    localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;
    localparam logic [OUT_COUNT-1:0] POLARITY_RESET = 6'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [OUT_COUNT-1:0] DOUT_RESET = 6'h3f;
    // Multi-segment sequence state.
    typedef enum logic {SEG_IDLE = 1'b0, SEG_RUN = 1'b1} seg_state_type;
endpackage : dispatch_pkg

// ---- rtl/dispatch_cfg_if.sv ----
// Configuration and status carrier between the register file and the dispatch core.
`timescale 1ns/1ns
interface dispatch_cfg_if import dispatch_pkg::*; ();
    logic [CODE_W-1:0] code [IN_COUNT]; // Function code per input terminal.
    logic [OUT_COUNT-1:0] polarity; // Output polarity, one bit per output.
    logic err_edge_mode; // Error clear acts on a rising edge when set.
    logic origin_edge_mode; // Origin input acts on a rising edge when set.
    logic [FN_COUNT-1:0] fn_status; // Registered effective state per function.
    logic [OUT_COUNT-1:0] dout_status; // Registered output terminal levels.
    modport regs (output code, polarity, err_edge_mode, origin_edge_mode,
                  input fn_status, dout_status);
    modport core (input polarity, err_edge_mode, origin_edge_mode,
                  output fn_status, dout_status);
    modport mapper (input code);
endinterface : dispatch_cfg_if

// ---- rtl/function_mapper.sv ----
// Maps input terminals onto function slots by their configured codes.
`timescale 1ns/1ns
module function_mapper
    import dispatch_pkg::*;
(
    dispatch_cfg_if.mapper cfg,
    input wire logic [IN_COUNT-1:0] din,
    output logic [FN_COUNT-1:0] fn_state
);
    // One slot per function code; several terminals on one code are ORed.
    genvar f;
    generate
        for (f = 0; f < FN_COUNT; f++)
        begin : g_slot
            logic hit; // Some terminal carrying this code is high.
            // Code zero and the unassigned code never collect a terminal.
            always_comb
            begin
                hit = 1'b0;
                if (f != FN_NONE && f != FN_UNASSIGNED)
                begin
                    for (int i = 0; i < IN_COUNT; i++)
                    begin
                        if (din[i] && cfg.code[i] == CODE_W'(f))
                        begin
                            hit = 1'b1;
                        end
                    end
                end
            end
            assign fn_state[f] = hit;
        end
    endgenerate
endmodule : function_mapper

// ---- rtl/dispatch_regs.sv ----
// APB register file holding function codes, polarities and trigger modes.
`timescale 1ns/1ns
module dispatch_regs
    import dispatch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dispatch_cfg_if.regs cfg
);
    logic [CODE_W-1:0] code [IN_COUNT]; // Stored function codes.
    logic [CODE_W-1:0] next_code [IN_COUNT];
    logic [OUT_COUNT-1:0] polarity; // Output polarity bits.
    logic [OUT_COUNT-1:0] next_polarity;
    logic [1:0] mode; // Error clear and origin trigger modes.
    logic [1:0] next_mode;
    logic [31:0] next_prdata;
    logic code_hit; // Address falls on one of the code words.
    logic mapped; // Address names a register.
    logic wr; // Write takes effect this edge.

    // Address decode is combinational so the access phase can answer at once.
    always_comb
    begin
        code_hit = paddr[ADDR_W-1:5] == '0 && paddr[1:0] == 2'h0;
        mapped = code_hit || paddr == ADDR_POLARITY || paddr == ADDR_MODE ||
                 paddr == ADDR_STATUS_LO || paddr == ADDR_STATUS_HI ||
                 paddr == ADDR_OUT_STATUS;
    end

    // Zero wait states; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr = psel && penable && pwrite && mapped && ce;

    // Next values: writes in the access phase, read data captured in setup.
    always_comb
    begin
        next_code = code;
        next_polarity = polarity;
        next_mode = mode;
        next_prdata = prdata;
        if (wr && code_hit)
        begin
            next_code[paddr[4:2]] = pwdata[CODE_W-1:0];
        end
        else if (wr && paddr == ADDR_POLARITY)
        begin
            next_polarity = pwdata[OUT_COUNT-1:0];
        end
        else if (wr && paddr == ADDR_MODE)
        begin
            next_mode = pwdata[1:0];
        end
        if (psel && !penable && !pwrite)
        begin
            if (code_hit)
            begin
                next_prdata = {25'h0, code[paddr[4:2]]};
            end
            else if (paddr == ADDR_POLARITY)
            begin
                next_prdata = {26'h0, polarity};
            end
            else if (paddr == ADDR_MODE)
            begin
                next_prdata = {30'h0, mode};
            end
            else if (paddr == ADDR_STATUS_LO)
            begin
                next_prdata = cfg.fn_status[31:0];
            end
            else if (paddr == ADDR_STATUS_HI)
            begin
                next_prdata = {14'h0, cfg.fn_status[FN_COUNT-1:32]};
            end
            else if (paddr == ADDR_OUT_STATUS)
            begin
                next_prdata = {26'h0, cfg.dout_status};
            end
            else
            begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    // Registers; clock enable low freezes them all.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code <= '{default: CODE_RESET};
            polarity <= POLARITY_RESET;
            mode <= MODE_RESET;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            code <= next_code;
            polarity <= next_polarity;
            mode <= next_mode;
            prdata <= next_prdata;
        end
    end

    assign cfg.code = code;
    assign cfg.polarity = polarity;
    assign cfg.err_edge_mode = mode[MODE_ERR_EDGE_BIT];
    assign cfg.origin_edge_mode = mode[MODE_ORIGIN_EDGE_BIT];
endmodule : dispatch_regs

// ---- rtl/digital_input_function_dispatch.sv ----
// Top of the input function dispatch and output polarity block.
`timescale 1ns/1ns
module digital_input_function_dispatch
    import dispatch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IN_COUNT-1:0] din,
    input wire logic [OUT_COUNT-1:0] do_valid,
    output logic [OUT_COUNT-1:0] dout,
    output logic [FN_COUNT-1:0] function_level,
    output logic servo_enable,
    output logic [FN_TQ_LAST-FN_TQ_FIRST:0] torque_speed_sel,
    output logic [3:0] speed_select,
    output logic pos_cmd_inhibit,
    output logic pos_cmd_reverse,
    output logic pulse_cmd_inhibit,
    output logic [3:0] seg_select,
    output logic seg_direction,
    output logic [1:0] mode_select,
    output logic fixlen_cancel,
    output logic limit_positive,
    output logic limit_negative,
    output logic drive_reset_pulse,
    output logic encoder_clear_pulse,
    output logic firmware_reset_pulse,
    output logic logic_reset_pulse,
    output logic home_start_pulse,
    output logic seg_start_pulse,
    output logic seg_stop_pulse,
    output logic seg_running,
    output logic fixlen_trigger_pulse,
    output logic error_clear,
    output logic origin_signal
);
    // Shared configuration and status between the register file and the core.
    dispatch_cfg_if cfg ();

    logic [FN_COUNT-1:0] fn_state; // Combinational effective state per function.
    logic [FN_COUNT-1:0] level; // Registered effective state.
    logic [FN_COUNT-1:0] next_level;
    logic [FN_COUNT-1:0] rise; // One-cycle pulses on low-to-high changes.
    logic [FN_COUNT-1:0] next_rise;
    logic [FN_COUNT-1:0] fall; // One-cycle pulses on high-to-low changes.
    logic [FN_COUNT-1:0] next_fall;
    logic fix_pulse; // Gated fixed-length trigger.
    logic next_fix_pulse;
    seg_state_type seg_state; // Multi-segment sequence state.
    seg_state_type next_seg_state;
    logic [OUT_COUNT-1:0] next_dout;

    // Register file on the APB side.
    dispatch_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cfg(cfg.regs)
    );

    // Terminals are taken as synchronous; a high terminal is effective.
    function_mapper u_mapper (
        .cfg(cfg.mapper),
        .din(din),
        .fn_state(fn_state)
    );

    // Edge detection compares the fresh state against last cycle's copy.
    // Registering the pulses keeps them aligned with the level they report.
    always_comb
    begin
        next_level = fn_state;
        next_rise = fn_state & ~level;
        next_fall = ~fn_state & level;
        // The trigger counts only while detection is enabled in the same cycle.
        next_fix_pulse = fn_state[FN_FIXLEN_TRIGGER] && !level[FN_FIXLEN_TRIGGER] &&
                         fn_state[FN_FIXLEN_DETECT];
    end

    // Level and edge registers; clock enable low holds them, so no edge is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level <= '0;
            rise <= '0;
            fall <= '0;
            fix_pulse <= 1'b0;
        end
        else if (ce)
        begin
            level <= next_level;
            rise <= next_rise;
            fall <= next_fall;
            fix_pulse <= next_fix_pulse;
        end
    end

    // Segment sequence: a rise starts it, a fall stops it.
    always_comb
    begin
        next_seg_state = seg_state;
        case (seg_state)
            SEG_IDLE:
            begin
                // Start on a low-to-high change of the trigger.
                if (fn_state[FN_SEG_TRIGGER] && !level[FN_SEG_TRIGGER])
                begin
                    next_seg_state = SEG_RUN;
                end
            end
            SEG_RUN:
            begin
                // Stop on a high-to-low change of the trigger.
                if (!fn_state[FN_SEG_TRIGGER] && level[FN_SEG_TRIGGER])
                begin
                    next_seg_state = SEG_IDLE;
                end
            end
            default:
            begin
                next_seg_state = SEG_IDLE;
            end
        endcase
    end

    // Segment state register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seg_state <= SEG_IDLE;
        end
        else if (ce)
        begin
            seg_state <= next_seg_state;
        end
    end

    // Output levels: a valid function drives the polarity level, else its inverse.
    always_comb
    begin
        next_dout = cfg.polarity ^ ~do_valid;
    end

    // Output terminal register; the reset level is the inactive one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout <= DOUT_RESET;
        end
        else if (ce)
        begin
            dout <= next_dout;
        end
    end

    // Status back to the register file.
    assign cfg.fn_status = level;
    assign cfg.dout_status = dout;

    // Level-held commands straight from the registered state.
    assign function_level = level;
    assign servo_enable = level[FN_ENABLE];
    assign torque_speed_sel = level[FN_TQ_LAST:FN_TQ_FIRST];
    assign speed_select = level[FN_SPEED_SEL3:FN_SPEED_SEL0];
    assign pos_cmd_inhibit = level[FN_POS_INHIBIT];
    assign pos_cmd_reverse = level[FN_POS_REVERSE];
    assign pulse_cmd_inhibit = level[FN_PULSE_INHIBIT];
    assign seg_select = level[FN_SEG_SEL3:FN_SEG_SEL0];
    assign seg_direction = level[FN_SEG_DIR];
    assign mode_select = level[FN_MODE_SEL1:FN_MODE_SEL0];
    assign fixlen_cancel = level[FN_FIXLEN_CANCEL];
    assign limit_positive = level[FN_LIMIT_POS];
    assign limit_negative = level[FN_LIMIT_NEG];

    // Edge-triggered commands: one clock-enabled cycle each, never repeated while held; seg_running follows the segment state.
    assign drive_reset_pulse = rise[FN_DRIVE_RESET];
    assign encoder_clear_pulse = rise[FN_ENC_CLEAR];
    assign firmware_reset_pulse = rise[FN_FW_RESET];
    assign logic_reset_pulse = rise[FN_LOGIC_RESET];
    assign home_start_pulse = rise[FN_HOME_START];
    assign seg_start_pulse = rise[FN_SEG_TRIGGER];
    assign seg_stop_pulse = fall[FN_SEG_TRIGGER];
    assign seg_running = seg_state == SEG_RUN;
    assign fixlen_trigger_pulse = fix_pulse;

    // Mode-dependent inputs: software picks level or edge behaviour.
    assign error_clear = cfg.err_edge_mode ? rise[FN_ERR_CLEAR] : level[FN_ERR_CLEAR];
    assign origin_signal = cfg.origin_edge_mode ? rise[FN_ORIGIN] : level[FN_ORIGIN];

    // Checks on the dispatch behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A low-to-high change of the segment trigger, seen at the mapper.
    sequence seg_rise_s;
        ce && fn_state[FN_SEG_TRIGGER] && !level[FN_SEG_TRIGGER];
    endsequence

    // A high-to-low change of the segment trigger, seen at the mapper.
    sequence seg_fall_s;
        ce && !fn_state[FN_SEG_TRIGGER] && level[FN_SEG_TRIGGER];
    endsequence

    // A rising edge of the drive reset function followed by a steady high.
    sequence reset_held_s;
        ce && fn_state[FN_DRIVE_RESET] && !level[FN_DRIVE_RESET] ##1
        ce && fn_state[FN_DRIVE_RESET];
    endsequence

    // Edge checks look at the previous enable, since a frozen clock stretches every pulse.
    none_ignored_a: assert property (!level[FN_NONE] && !level[FN_UNASSIGNED])
        else $error("Code zero or unassigned code became active.");

    status_follows_a: assert property (ce |=> cfg.fn_status == $past(fn_state))
        else $error("Status does not follow the effective input state.");

    frozen_hold_a: assert property (!ce |=> level == $past(level) && dout == $past(dout))
        else $error("State moved while the clock enable was low.");

    enable_level_a: assert property (ce && fn_state[FN_ENABLE] |=> servo_enable)
        else $error("Enable did not follow its input.");

    reset_once_a: assert property (reset_held_s |-> drive_reset_pulse ##1 !drive_reset_pulse)
        else $error("Drive reset pulse missing or repeated while held.");

    enc_clear_edge_a: assert property (ce && fn_state[FN_ENC_CLEAR] && !level[FN_ENC_CLEAR]
        |=> encoder_clear_pulse)
        else $error("Encoder clear missing after rising edge.");

    fw_reset_edge_a: assert property (firmware_reset_pulse && $past(ce)
        |-> !$past(level[FN_FW_RESET]))
        else $error("Firmware reset fired without a rising edge.");

    logic_reset_edge_a: assert property (logic_reset_pulse && $past(ce)
        |-> !$past(level[FN_LOGIC_RESET]) && level[FN_LOGIC_RESET])
        else $error("Logic reset fired without a rising edge.");

    speed_bits_a: assert property (ce |=> speed_select == $past(fn_state[20:17]))
        else $error("Speed select bits do not match their inputs.");

    inhibit_level_a: assert property (ce && fn_state[FN_POS_INHIBIT] |=> pos_cmd_inhibit)
        else $error("Position inhibit not applied.");

    home_edge_a: assert property (ce && fn_state[26] && !level[26] |=> home_start_pulse)
        else $error("Homing start missing after rising edge.");

    seg_start_a: assert property (seg_rise_s |=> seg_start_pulse && seg_running)
        else $error("Segment sequence did not start on rise.");

    seg_stop_a: assert property (seg_fall_s |=> seg_stop_pulse && !seg_running)
        else $error("Segment sequence did not stop on fall.");

    seg_index_a: assert property (ce |=> seg_select == $past(fn_state[31:28]))
        else $error("Segment index bits do not match their inputs.");

    origin_edge_a: assert property (cfg.origin_edge_mode && origin_signal && $past(ce)
        |-> level[FN_ORIGIN] && !$past(level[FN_ORIGIN]))
        else $error("Origin signal active without an edge in edge mode.");

    mode_bits_a: assert property (ce |=> mode_select == $past(fn_state[37:36]))
        else $error("Control mode bits do not match their inputs.");

    fixlen_gate_a: assert property (fixlen_trigger_pulse |-> level[FN_FIXLEN_DETECT])
        else $error("Fixed-length trigger passed without detection enabled.");

    fixlen_fire_a: assert property (ce && fn_state[FN_FIXLEN_DETECT] &&
        fn_state[FN_FIXLEN_TRIGGER] && !level[FN_FIXLEN_TRIGGER] |=> fixlen_trigger_pulse)
        else $error("Fixed-length trigger dropped while detection was enabled.");

    cancel_level_a: assert property (ce && fn_state[39] |=> fixlen_cancel)
        else $error("Fixed-length cancel not applied.");

    limit_level_a: assert property (ce && fn_state[43] |=> limit_positive)
        else $error("Positive limit not applied.");

    limit_neg_a: assert property (ce && fn_state[FN_LIMIT_NEG] |=> limit_negative)
        else $error("Reverse limit not applied.");

    polarity_out_a: assert property (ce |=> dout == $past(cfg.polarity ^ ~do_valid))
        else $error("Output level does not match polarity and validity.");

    err_level_a: assert property (ce && !cfg.err_edge_mode ##1 !cfg.err_edge_mode
        |-> error_clear == $past(fn_state[FN_ERR_CLEAR]))
        else $error("Error clear not level-driven in level mode.");

    err_edge_a: assert property (cfg.err_edge_mode && error_clear && $past(ce)
        |-> level[FN_ERR_CLEAR] && !$past(level[FN_ERR_CLEAR]))
        else $error("Error clear fired without a rising edge in edge mode.");
endmodule : digital_input_function_dispatch

// ---- dv/switch_bank.sv ----
// Model of the field switches that drive the input terminals.
`timescale 1ns/1ns
module switch_bank
    import dispatch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [IN_COUNT-1:0] press,
    output logic [IN_COUNT-1:0] din
);
    // Contacts settle one clock after they move; open contacts read low through pull-downs.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            din <= '0;
        else
            din <= press;
    end
endmodule : switch_bank

// ---- dv/digital_input_function_dispatch_tb_top.sv ----
// Self-checking bench for the input function dispatch block.
`timescale 1ns/1ns
module digital_input_function_dispatch_tb_top
    import dispatch_pkg::*;
;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, chk_on, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, pw;
    logic [IN_COUNT-1:0] press, din;
    logic [OUT_COUNT-1:0] do_valid, dout, pol, ed;
    logic [FN_COUNT-1:0] function_level, lv, el, rise;
    logic [28:0] got_lv; // Level command outputs, packed.
    logic [10:0] got_p, ep; // Pulse and mode-dependent outputs, packed.
    logic [CODE_W-1:0] code_m [IN_COUNT]; // Bench copy of the code registers.
    logic [1:0] mode_m;
    int fail_count, comparisons, cycles, seed, cw;
    switch_bank sw (.pclk(pclk), .presetn(presetn), .press(press), .din(din));
    digital_input_function_dispatch dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .din(din), .do_valid(do_valid), .dout(dout),
        .function_level(function_level), .servo_enable(got_lv[28]),
        .torque_speed_sel(got_lv[27:17]), .speed_select(got_lv[16:13]),
        .pos_cmd_inhibit(got_lv[12]), .pos_cmd_reverse(got_lv[11]),
        .pulse_cmd_inhibit(got_lv[10]), .seg_select(got_lv[9:6]), .seg_direction(got_lv[5]),
        .mode_select(got_lv[4:3]), .fixlen_cancel(got_lv[2]), .limit_positive(got_lv[1]),
        .limit_negative(got_lv[0]), .drive_reset_pulse(got_p[10]),
        .encoder_clear_pulse(got_p[9]), .firmware_reset_pulse(got_p[8]),
        .logic_reset_pulse(got_p[7]), .home_start_pulse(got_p[6]), .seg_start_pulse(got_p[5]),
        .seg_stop_pulse(got_p[4]), .seg_running(got_p[3]), .fixlen_trigger_pulse(got_p[2]),
        .error_clear(got_p[1]), .origin_signal(got_p[0]));
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Reference model: only clock-enabled edges move it, like the flops it mirrors.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            el <= '0;
            ep <= '0;
            ed <= 6'h3f;
        end
        else if (ce)
        begin
            lv = '0;
            for (int i = 0; i < IN_COUNT; i++)
                if (din[i] && code_m[i] != 0 && code_m[i] != 33 && code_m[i] < 50)
                    lv[code_m[i]] = 1'b1;
            rise = lv & ~el;
            ep <= {rise[2], rise[15], rise[14], rise[46], rise[26], rise[27], el[27] & ~lv[27],
                lv[27], rise[40] & lv[38], mode_m[0] ? rise[25] : lv[25],
                mode_m[1] ? rise[34] : lv[34]};
            el <= lv;
            ed <= ~(pol ^ do_valid);
        end
    end
    // Counts every comparison and reports a mismatch at once.
    task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // One APB transfer; the request holds until pready is seen high at an edge.
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task tally_and_finish;
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // Every result is compared against the model once it has settled.
    always @(negedge pclk)
    begin
        if (chk_on)
        begin
            cmp("function_level", 64'(el), 64'(function_level));
            cmp("levels", 64'({el[1], el[13:3], el[20:17], el[21], el[22], el[23], el[31:28],
                el[32], el[37:36], el[39], el[43], el[44]}), 64'(got_lv));
            cmp("pulses", 64'(ep), 64'(got_p));
            cmp("dout", 64'(ed), 64'(dout));
        end
    end
    // Hang guard, well above the expected run length.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Reset checks, then eight code maps covering every code, duplicates and refused codes.
    initial
    begin
        {presetn, psel, penable, pwrite, chk_on, paddr, pwdata, press, do_valid} = '0;
        ce = 1'b1;
        pol = '0;
        mode_m = '0;
        seed = 20;
        foreach (code_m[i]) code_m[i] = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cmp("dout_reset", 64'h3f, 64'(dout));
        for (int i = 0; i < IN_COUNT; i++)
        begin
            apb(1'b0, ADDR_W'(4 * i), 32'h0);
            cmp("code_reset", 64'h0, 64'(rd));
        end
        apb(1'b0, ADDR_POLARITY, 32'h0);
        cmp("polarity_reset", 64'h0, 64'(rd));
        apb(1'b0, 12'h034, 32'h0);
        cmp("unmapped", 64'h1_0000_0000, 64'({er, rd}));
        for (int r = 0; r < 8; r++)
        begin
            chk_on = 1'b0;
            press <= '0;
            repeat (3) @(posedge pclk);
            for (int i = 0; i < IN_COUNT; i++)
            begin
                // The last map repeats the fixed-length codes so that inputs are ORed.
                // Inputs six and seven carry the error clear and origin codes again.
                cw = (r == 7) ? (i > 5 ? 25 + 9 * (i - 6) : 38 + i % 3) : r * 8 + i;
                apb(1'b1, ADDR_W'(4 * i), 32'(cw));
                code_m[i] = CODE_W'(cw);
            end
            pw = $random(seed);
            apb(1'b1, ADDR_POLARITY, pw);
            pol = pw[5:0];
            // Each mode-dependent code meets both of its trigger modes across the maps.
            cw = (r % 4) ^ (r / 4 * 3);
            apb(1'b1, ADDR_MODE, 32'(cw));
            mode_m = 2'(cw);
            apb(1'b0, ADDR_POLARITY, 32'h0);
            cmp("polarity", 64'(pw[5:0]), 64'(rd[5:0]));
            repeat (2) @(posedge pclk);
            chk_on = 1'b1;
            repeat (40)
            begin
                @(posedge pclk);
                press <= IN_COUNT'($random(seed));
                ce <= ($random(seed) & 3) != 0;
                do_valid <= OUT_COUNT'($random(seed));
            end
            @(posedge pclk);
            ce <= 1'b1;
            repeat (3) @(posedge pclk);
            apb(1'b0, ADDR_STATUS_LO, 32'h0);
            cmp("status_lo", 64'(el[31:0]), 64'(rd));
            apb(1'b0, ADDR_STATUS_HI, 32'h0);
            cmp("status_hi", 64'(el[49:32]), 64'(rd));
            apb(1'b0, ADDR_OUT_STATUS, 32'h0);
            cmp("out_status", 64'(ed), 64'(rd));
        end
        tally_and_finish();
    end
endmodule : digital_input_function_dispatch_tb_top
